// file: include/spwm_pkg.sv
// spwm_pkg: register map, field layout, reset values and modes of the standard pwm channel
// assumes an apb slave at 32-bit data, one register per aligned word
package spwm_pkg;
   // =====================================================
   // register byte offsets
   localparam logic [7:0] SPWM_OFF_CTRL    = 8'h00;
   localparam logic [7:0] SPWM_OFF_DUTYW   = 8'h04;
   localparam logic [7:0] SPWM_OFF_SHADOW  = 8'h08;
   localparam logic [7:0] SPWM_OFF_TSELA   = 8'h0C;
   localparam logic [7:0] SPWM_OFF_TSELB   = 8'h10;
   localparam logic [7:0] SPWM_OFF_PERIOD  = 8'h14;
   localparam logic [7:0] SPWM_OFF_TCTRL   = 8'h18;
   localparam logic [7:0] SPWM_OFF_COUNT   = 8'h1C;
   localparam logic [7:0] SPWM_OFF_PINCTL  = 8'h20;
   localparam logic [7:0] SPWM_OFF_STATUS  = 8'h24;
   // =====================================================
   // field positions
   localparam int SPWM_DCLO_LSB   = 4;
   localparam int SPWM_TSEL_LSB   = 0;
   localparam int SPWM_TON_BIT    = 2;
   localparam int SPWM_PINDIR_BIT = 0;
   localparam int SPWM_ALTSEL_BIT = 1;
   localparam int SPWM_SLEEP_BIT  = 2;
   // =====================================================
   // reset values
   localparam logic [7:0] SPWM_RST_CTRL   = 8'h00;
   localparam logic [7:0] SPWM_RST_DUTY   = 8'h00;
   localparam logic [7:0] SPWM_RST_PERIOD = 8'hFF;
   localparam logic [7:0] SPWM_RST_TCTRL  = 8'h00;
   localparam logic [2:0] SPWM_RST_PINCTL = 3'h1;
   // mode field codes 4'b11xx select pwm
   localparam logic [1:0] SPWM_MODE_PWM   = 2'h3;
   // timer prescale codes
   localparam logic [1:0] SPWM_PS_1       = 2'h0;
   localparam logic [1:0] SPWM_PS_4       = 2'h1;
   localparam logic [1:0] SPWM_PS_16      = 2'h2;
   localparam logic [1:0] SPWM_PS_64      = 2'h3;
   // clock phases per timer step at 1:1
   localparam int SPWM_PHASES     = 4;
endpackage : spwm_pkg

// file: hdl/spwm_top.sv
// spwm_top: single-output pwm channel with three 8-bit timers, apb register slave
// assumes pclk is the oscillator clock; pin pad resolves from pin_out/pin_oe
//
// Our own choices: register access over APB and the register addresses.
`timescale 1ns/1ps
module spwm_top #(
   parameter int CH_SEL = 0
) (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   output logic             pwm_output_pin,
   output logic             pwm_output_pin_oe,
   output logic             pwm_output_alt,
   output logic             pwm_output_alt_oe
);
   // =====================================================
   // registers
   logic [7:0]  pwm_channel_control_r;
   logic [7:0]  duty_write_register_r;
   logic [7:0]  duty_shadow_register_r;
   logic [1:0]  duty_latch_r;
   logic [7:0]  channel_timer_select_a_r;
   logic [1:0]  channel_timer_select_b_r;
   logic [7:0]  timer_period_limit_r [3];
   logic [7:0]  timer_control_r      [3];
   logic [7:0]  timer_count_value_r  [3];
   logic [5:0]  prescale_r           [3];
   logic [1:0]  phase_r;
   logic [2:0]  pin_ctl_r;
   logic        pwm_level_r;
   logic        wr_en;
   logic        rd_en;
   logic        pwm_active;
   logic        sleeping;
   logic [1:0]  sel;
   logic [1:0]  tick_low [3];
   logic        tick     [3];
   logic        step     [3];
   logic        match    [3];
   logic [9:0]  time_base;
   logic [9:0]  duty_val;
   logic [31:0] rdata_nxt;

   // shared decode of the timer choice field
   function automatic logic [1:0] spwm_tsel(input logic [7:0] a, input logic [1:0] b);
      logic [1:0] r;
      r = (CH_SEL < 4) ? a[2*CH_SEL +: 2] : b;
      return (r == 2'h3) ? 2'h0 : r;
   endfunction : spwm_tsel

   assign wr_en      = psel && penable && pwrite;
   assign rd_en      = psel && penable && !pwrite;
   assign pwm_active = (pwm_channel_control_r[3:2] == spwm_pkg::SPWM_MODE_PWM);
   assign sleeping   = pin_ctl_r[spwm_pkg::SPWM_SLEEP_BIT];
   assign sel        = spwm_tsel(channel_timer_select_a_r, channel_timer_select_b_r);

   // =====================================================
   // phase counter: four clocks per timer step at 1:1
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         phase_r <= 2'h0;
      end else if (!sleeping) begin
         phase_r <= phase_r + 2'h1;
      end
   end

   // =====================================================
   // three timers; postscaler bits are stored but never used here
   genvar g;
   generate
      for (g = 0; g < 3; g++) begin : g_tmr
         logic [1:0] ps;
         logic       on;
         assign ps = timer_control_r[g][1:0];
         assign on = timer_control_r[g][spwm_pkg::SPWM_TON_BIT];
         // prescaler gives the two low time-base bits above 1:1
         // step: the 10-bit time base advances at this edge
         always_comb begin
            tick[g]     = 1'b0;
            step[g]     = 1'b1;
            tick_low[g] = phase_r;
            unique case (ps)
               spwm_pkg::SPWM_PS_1: begin
                  tick[g] = (phase_r == 2'h3);
               end
               spwm_pkg::SPWM_PS_4: begin
                  tick[g]     = (phase_r == 2'h3) && (prescale_r[g][1:0] == 2'h3);
                  step[g]     = (phase_r == 2'h3);
                  tick_low[g] = prescale_r[g][1:0];
               end
               spwm_pkg::SPWM_PS_16: begin
                  tick[g]     = (phase_r == 2'h3) && (prescale_r[g][3:0] == 4'hF);
                  step[g]     = (phase_r == 2'h3) && (prescale_r[g][1:0] == 2'h3);
                  tick_low[g] = prescale_r[g][3:2];
               end
               spwm_pkg::SPWM_PS_64: begin
                  tick[g]     = (phase_r == 2'h3) && (prescale_r[g] == 6'h3F);
                  step[g]     = (phase_r == 2'h3) && (prescale_r[g][3:0] == 4'hF);
                  tick_low[g] = prescale_r[g][5:4];
               end
            endcase
            tick[g] = tick[g] && on && !sleeping;
            step[g] = step[g] && on && !sleeping;
         end
         assign match[g] = tick[g] && (timer_count_value_r[g] == timer_period_limit_r[g]);

         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               prescale_r[g] <= 6'h00;
            end else if (on && !sleeping && phase_r == 2'h3) begin
               prescale_r[g] <= prescale_r[g] + 6'h01;
            end
         end

         // sleep holds the count, wake resumes from it
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               timer_count_value_r[g] <= 8'h00;
            end else if (wr_en && paddr == spwm_pkg::SPWM_OFF_COUNT && sel == 2'(g)) begin
               timer_count_value_r[g] <= pwdata[7:0];
            end else if (match[g]) begin
               timer_count_value_r[g] <= 8'h00;
            end else if (tick[g]) begin
               timer_count_value_r[g] <= timer_count_value_r[g] + 8'h01;
            end
         end

         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               timer_period_limit_r[g] <= spwm_pkg::SPWM_RST_PERIOD;
               timer_control_r[g]      <= spwm_pkg::SPWM_RST_TCTRL;
            end else if (wr_en && sel == 2'(g)) begin
               if (paddr == spwm_pkg::SPWM_OFF_PERIOD) begin
                  timer_period_limit_r[g] <= pwdata[7:0];
               end
               if (paddr == spwm_pkg::SPWM_OFF_TCTRL) begin
                  timer_control_r[g] <= {1'b0, pwdata[6:0]};
               end
            end
         end
      end
   endgenerate

   // 10-bit time base, resolution set by the chosen period
   assign time_base = {timer_count_value_r[sel], tick_low[sel]};
   assign duty_val  = {duty_shadow_register_r, duty_latch_r};

   // =====================================================
   // software registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pwm_channel_control_r    <= spwm_pkg::SPWM_RST_CTRL;
         duty_write_register_r    <= spwm_pkg::SPWM_RST_DUTY;
         channel_timer_select_a_r <= 8'h00;
         channel_timer_select_b_r <= 2'h0;
         pin_ctl_r                <= spwm_pkg::SPWM_RST_PINCTL;
      end else if (wr_en) begin // writes allowed any time
         unique case (paddr)
            spwm_pkg::SPWM_OFF_CTRL:   pwm_channel_control_r    <= pwdata[7:0];
            spwm_pkg::SPWM_OFF_DUTYW:  duty_write_register_r    <= pwdata[7:0];
            spwm_pkg::SPWM_OFF_TSELA:  channel_timer_select_a_r <= pwdata[7:0];
            spwm_pkg::SPWM_OFF_TSELB:  channel_timer_select_b_r <= pwdata[1:0];
            spwm_pkg::SPWM_OFF_PINCTL: pin_ctl_r                <= pwdata[2:0];
            default: ;
         endcase
      end
   end

   // =====================================================
   // double buffer: in pwm mode shadow and hidden latch load only at rollover
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         duty_shadow_register_r <= spwm_pkg::SPWM_RST_DUTY;
         duty_latch_r           <= 2'h0;
      end else if (pwm_active && match[sel]) begin
         duty_shadow_register_r <= duty_write_register_r;
         duty_latch_r <= pwm_channel_control_r[spwm_pkg::SPWM_DCLO_LSB +: 2];
      end else if (!pwm_active && wr_en && paddr == spwm_pkg::SPWM_OFF_SHADOW) begin
         duty_shadow_register_r <= pwdata[7:0]; // writable only outside pwm
      end
   end

   // =====================================================
   // output level; rollover set uses the duty being loaded
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pwm_level_r <= 1'b0;
      end else if (pwm_active && match[sel]) begin
         pwm_level_r <= ({duty_write_register_r,
                          pwm_channel_control_r[spwm_pkg::SPWM_DCLO_LSB +: 2]} != 10'h000);
      end else if (pwm_active && step[sel] && (time_base + 10'h001) == duty_val) begin
         // cleared as the time base reaches duty, so high for exactly duty steps
         pwm_level_r <= 1'b0;
      end
      // duty beyond period never matches, level simply holds
   end

   // =====================================================
   // pin mux; zero control returns the pin to port control
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pwm_output_pin    <= 1'b0;
         pwm_output_pin_oe <= 1'b0;
         pwm_output_alt    <= 1'b0;
         pwm_output_alt_oe <= 1'b0;
      end else begin
         pwm_output_pin    <= pwm_level_r && !pin_ctl_r[spwm_pkg::SPWM_ALTSEL_BIT];
         pwm_output_alt    <= pwm_level_r && pin_ctl_r[spwm_pkg::SPWM_ALTSEL_BIT];
         // driver also needs the direction bit cleared by software
         pwm_output_pin_oe <= pwm_active && !pin_ctl_r[spwm_pkg::SPWM_PINDIR_BIT]
                              && !pin_ctl_r[spwm_pkg::SPWM_ALTSEL_BIT];
         pwm_output_alt_oe <= pwm_active && !pin_ctl_r[spwm_pkg::SPWM_PINDIR_BIT]
                              && pin_ctl_r[spwm_pkg::SPWM_ALTSEL_BIT];
      end
   end

   // =====================================================
   // apb read mux; unmapped reads zero with pslverr
   always_comb begin
      rdata_nxt = 32'h0000_0000;
      unique case (paddr)
         spwm_pkg::SPWM_OFF_CTRL:   rdata_nxt[7:0] = pwm_channel_control_r;
         spwm_pkg::SPWM_OFF_DUTYW:  rdata_nxt[7:0] = duty_write_register_r;
         spwm_pkg::SPWM_OFF_SHADOW: rdata_nxt[7:0] = duty_shadow_register_r;
         spwm_pkg::SPWM_OFF_TSELA:  rdata_nxt[7:0] = channel_timer_select_a_r;
         spwm_pkg::SPWM_OFF_TSELB:  rdata_nxt[1:0] = channel_timer_select_b_r;
         spwm_pkg::SPWM_OFF_PERIOD: rdata_nxt[7:0] = timer_period_limit_r[sel];
         spwm_pkg::SPWM_OFF_TCTRL:  rdata_nxt[7:0] = timer_control_r[sel];
         spwm_pkg::SPWM_OFF_COUNT:  rdata_nxt[7:0] = timer_count_value_r[sel];
         spwm_pkg::SPWM_OFF_PINCTL: rdata_nxt[2:0] = pin_ctl_r;
         spwm_pkg::SPWM_OFF_STATUS: rdata_nxt[10:0] = {pwm_level_r, duty_val};
         default: ;
      endcase
   end

   // one wait state: answer registered, pready high in second access cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata  <= 32'h0000_0000;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready  <= psel && penable && !pready;
         prdata  <= rd_en ? rdata_nxt : 32'h0000_0000;
         pslverr <= psel && penable && !pready && (paddr > spwm_pkg::SPWM_OFF_STATUS
                                                   || paddr[1:0] != 2'h0);
      end
   end
endmodule : spwm_top

// file: bench/spwm_load.sv
// spwm_load: external load on the pwm pad, seen at either pin position
// assumes at most one position drives at a time; pulled low when undriven
`timescale 1ns/1ps
module spwm_load (
   input  wire logic pin,
   input  wire logic pin_oe,
   input  wire logic alt,
   input  wire logic alt_oe,
   output wire logic pad
);
   // ======================================
   // pad level
   // pull-down, so a released pad reads low, never a stale level
   assign pad = pin_oe ? pin : (alt_oe ? alt : 1'b0);
endmodule : spwm_load

// file: bench/spwm_assertions.sv
// spwm_assertions: port checks on the apb slave and the pin enables
// assumes the spwm_top ports and the single pclk domain
`timescale 1ns/1ps
module spwm_assertions (
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        pwm_output_pin_oe,
   input wire logic        pwm_output_alt_oe
);
   // ======================================
   // properties
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence s_setup; psel && !penable; endsequence
   sequence s_access; psel && penable; endsequence
   property p_access_two; s_setup ##1 s_access |-> !pready ##1 pready; endproperty
   property p_ready_pulse; pready |=> !pready; endproperty
   property p_ready_cause; pready |-> psel && penable && $past(psel && penable); endproperty
   property p_err_map; pready |-> pslverr == (paddr > 8'h24 || paddr[1:0] != 2'h0); endproperty
   property p_err_only; pslverr |-> pready; endproperty
   property p_rdata_idle; !pready && !$past(pready) |-> prdata == 32'h0; endproperty
   property p_idle; !psel |=> !pready; endproperty
   property p_one_pin; !(pwm_output_pin_oe && pwm_output_alt_oe); endproperty
   a_access_two: assert property (p_access_two) else $error("access not two cycles");
   a_ready_pulse: assert property (p_ready_pulse) else $error("pready longer than one cycle");
   a_ready_cause: assert property (p_ready_cause) else $error("pready without access");
   a_err_map: assert property (p_err_map) else $error("pslverr wrong for address");
   a_err_only: assert property (p_err_only) else $error("pslverr without pready");
   a_rdata_idle: assert property (p_rdata_idle) else $error("prdata not zero when idle");
   a_idle: assert property (p_idle) else $error("pready with no select");
   a_one_pin: assert property (p_one_pin) else $error("both pin positions driven");
endmodule : spwm_assertions

bind spwm_top spwm_assertions u_chk (.pclk, .presetn, .psel, .penable, .paddr, .prdata,
   .pready, .pslverr, .pwm_output_pin_oe, .pwm_output_alt_oe);

// file: bench/testbench.sv
// testbench: apb register tests and pad duty measurement of the pwm channel
// assumes spwm_top with CH_SEL 0, the spwm_load pad model and timer select 0
`timescale 1ns/1ps
module testbench;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, se;
   logic        pin, pin_oe, alt, alt_oe, pad;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, q, a;
   logic [1:0]  d2;
   int          bad_count = 0;
   int          tests_run = 0;
   int          h;
   logic [9:0]  duty_tab [6] = '{10'd0, 10'd1, 10'd6, 10'd15, 10'd16, 10'd21};
   spwm_top #(.CH_SEL(0)) uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr, .pwm_output_pin(pin), .pwm_output_pin_oe(pin_oe),
      .pwm_output_alt(alt), .pwm_output_alt_oe(alt_oe));
   spwm_load u_load (.pin, .pin_oe, .alt, .alt_oe, .pad);
   // ======================================
   // tasks
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         bad_count++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   // entered just after a rising edge; one idle edge after each transfer
   task automatic xfer(input logic w, input logic [7:0] ad, input logic [31:0] d);
      int n;
      n = 0;
      {psel, pwrite, paddr, pwdata} <= {1'b1, w, ad, d};
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      q = prdata;
      se = pslverr;
      {psel, penable} <= 2'b00;
      if (n >= 50) bad_count++;
      @(posedge pclk);
   endtask : xfer
   task automatic wr(input logic [7:0] ad, input logic [7:0] d);
      xfer(1'b1, ad, {24'h0, d});
   endtask : wr
   task automatic rdc(input logic [7:0] ad, input logic [31:0] exp);
      xfer(1'b0, ad, 32'h0);
      chk(q, exp);
   endtask : rdc
   task automatic meas(input int n);
      h = 0;
      repeat (n) begin
         @(posedge pclk);
         if (pad === 1'b1) h++;
      end
   endtask : meas
   task automatic end_sim;
      $display("comparisons %0d mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : end_sim
   // ======================================
   // clock, watchdog, tests
   initial begin
      pclk = 1'b0;
      forever #4 pclk = ~pclk;
   end
   initial begin
      repeat (20000) @(posedge pclk);
      bad_count++;
      end_sim();
   end
   initial begin
      {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      rdc(spwm_pkg::SPWM_OFF_CTRL, 32'h00);
      rdc(spwm_pkg::SPWM_OFF_DUTYW, 32'h00);
      rdc(spwm_pkg::SPWM_OFF_PERIOD, 32'hFF);
      rdc(spwm_pkg::SPWM_OFF_TCTRL, 32'h00);
      rdc(spwm_pkg::SPWM_OFF_PINCTL, 32'h01);
      xfer(1'b0, 8'h30, 32'h0);
      chk(se, 1'b1);
      $display("test reset values done");
      wr(spwm_pkg::SPWM_OFF_PERIOD, 8'h03);
      wr(spwm_pkg::SPWM_OFF_TCTRL, 8'h04);
      wr(spwm_pkg::SPWM_OFF_PINCTL, 8'h00);
      foreach (duty_tab[i]) begin
         wr(spwm_pkg::SPWM_OFF_CTRL, {2'b00, duty_tab[i][1:0], 4'hC});
         wr(spwm_pkg::SPWM_OFF_DUTYW, duty_tab[i][9:2]);
         repeat (40) @(posedge pclk);
         meas(32);
         chk(h, (duty_tab[i] >= 10'd16) ? 32 : 2 * duty_tab[i]);
         rdc(spwm_pkg::SPWM_OFF_SHADOW, {24'h0, duty_tab[i][9:2]});
         xfer(1'b0, spwm_pkg::SPWM_OFF_STATUS, 32'h0);
         chk(q[9:0], duty_tab[i]);
      end
      wr(spwm_pkg::SPWM_OFF_SHADOW, 8'hAA);
      rdc(spwm_pkg::SPWM_OFF_SHADOW, 32'h05);
      $display("test duty table done");
      wr(spwm_pkg::SPWM_OFF_PINCTL, 8'h04);
      xfer(1'b0, spwm_pkg::SPWM_OFF_COUNT, 32'h0);
      a = q;
      repeat (20) @(posedge pclk);
      rdc(spwm_pkg::SPWM_OFF_COUNT, a);
      wr(spwm_pkg::SPWM_OFF_PINCTL, 8'h00);
      repeat (2) @(posedge pclk);
      xfer(1'b0, spwm_pkg::SPWM_OFF_COUNT, 32'h0);
      d2 = q[1:0] - a[1:0];
      chk(d2 inside {2'h1, 2'h2}, 1'b1);
      $display("test sleep done");
      wr(spwm_pkg::SPWM_OFF_DUTYW, 8'h02);
      wr(spwm_pkg::SPWM_OFF_CTRL, 8'h2C);
      wr(spwm_pkg::SPWM_OFF_TCTRL, 8'h7D);
      repeat (140) @(posedge pclk);
      meas(128);
      chk(h, 80);
      $display("test prescale done");
      wr(spwm_pkg::SPWM_OFF_PINCTL, 8'h02);
      repeat (3) @(posedge pclk);
      chk({pin_oe, alt_oe}, 2'b01);
      wr(spwm_pkg::SPWM_OFF_CTRL, 8'h00);
      repeat (3) @(posedge pclk);
      chk({pin_oe, alt_oe}, 2'b00);
      $display("test pin position done");
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      rdc(spwm_pkg::SPWM_OFF_PERIOD, 32'hFF);
      rdc(spwm_pkg::SPWM_OFF_PINCTL, 32'h01);
      $display("test second reset done");
      end_sim();
   end
endmodule : testbench
